// file: include/two_wire_pkg.sv
// shared constants and types of the two-wire slave register port
// =====================================================================
`default_nettype none
package two_wire_pkg;
  // system clock and idle timeout
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BUS_IDLE_TIMEOUT_MS = 35;
  localparam int unsigned BUS_IDLE_TIMEOUT_CYCLES = BUS_IDLE_TIMEOUT_MS * (CLK_HZ / 1000);
  // reset addresses the address inputs are expected to carry
  localparam logic [7:0] DEF_PRIMARY_ADDR = 8'hd0;
  localparam logic [7:0] DEF_PRIMARY_READ_ADDR = 8'hd1;
  localparam logic [6:0] HIGH_PAGES_STEP = 7'h01;
  // page control register layout
  localparam int PCTL_AUTO_PAGE_RETURN_BIT = 7;
  localparam int PCTL_WMODE_BIT = 6;
  localparam int PCTL_PAGE_MSB = 1;
  localparam logic [7:0] PCTL_PAGE_MASK = 8'h07;
  localparam logic [7:0] PCTL_RESET = 8'h00;
  localparam logic [6:0] PAGE_CTL_OFFSET = 7'h00;
  // protocol figures
  localparam logic [4:0] MASTER_CODE_TOP = 5'h01;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // bit counter parks here after START; the clock fall that ends the START wraps it to 0
  localparam logic [3:0] START_FALL_BIT = 4'hf;
  localparam int REG_ADDR_W = 9;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEVADDR = 3'b001,
    ST_REGADDR = 3'b011,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b110,
    ST_SKIP = 3'b100
  } link_state_e;
endpackage
`default_nettype wire

// file: design/bus_line_sync.sv
// two-flop synchroniser with a one-sample spike filter for a bus line
`default_nettype none
module bus_line_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // line
  input wire logic din,
  input wire logic bypass,
  output logic dout
);
  logic meta, s1, s2;

  // lines idle high, so reset to one and never fake a START
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b1;
      s1 <= 1'b1;
      s2 <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      s1 <= meta;
      s2 <= s1;
      if (bypass || s1 == s2) begin
        dout <= s1;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/event_cross.sv
// toggle crossing of a one-cycle event between two clock domains
`default_nettype none
module event_cross (
  // source side
  input wire logic src_clk,
  input wire logic src_rstn,
  input wire logic src_pulse,
  // destination side
  input wire logic dst_clk,
  input wire logic dst_rstn,
  output logic dst_pulse
);
  logic src_tgl;
  logic [2:0] dst_sync;

  always_ff @(posedge src_clk or negedge src_rstn) begin
    if (!src_rstn) begin
      src_tgl <= 1'b0;
    end else if (src_pulse) begin
      src_tgl <= ~src_tgl;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rstn) begin
    if (!dst_rstn) begin
      dst_sync <= 3'h0;
    end else begin
      dst_sync <= {dst_sync[1:0], src_tgl};
    end
  end

  assign dst_pulse = dst_sync[2] ^ dst_sync[1];
endmodule
`default_nettype wire

// file: design/two_wire_slave_register_port.sv
// two-wire slave register port: bus engine on link_clk, register side on clk
`default_nettype none
module two_wire_slave_register_port #(
  parameter int unsigned TIMEOUT_CYCLES = two_wire_pkg::BUS_IDLE_TIMEOUT_CYCLES
) (
  // clocks and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic link_clk,
  // configuration, clk domain
  input wire logic two_wire_select,
  input wire logic [7:0] primary_bus_address,
  input wire logic [7:0] alternate_bus_address,
  input wire logic address_pick_enable,
  input wire logic hs_mode_always,
  input wire logic bus_idle_timeout_enable,
  // pins
  input wire logic general_input,
  input wire logic serial_clock_pin,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe_n,
  output logic shared_pins_free,
  // link-domain status
  output logic [7:0] page_control,
  output logic hs_mode,
  // register side, clk domain
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [two_wire_pkg::REG_ADDR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_exists
);
  localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam int CFG_W = 18;

  // =====================================================================
  // link-domain reset and synchronisers
  logic lrst_meta, lrstn;
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lrst_meta <= 1'b0;
      lrstn <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrstn <= lrst_meta;
    end
  end

  // quasi-static settings change only between frames, so bitwise sync is safe
  logic [CFG_W-1:0] cfg_meta, cfg;
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      cfg_meta <= '0;
      cfg <= '0;
    end else begin
      cfg_meta <= {two_wire_select, address_pick_enable, hs_mode_always, general_input,
                   primary_bus_address[7:1], alternate_bus_address[7:1]};
      cfg <= cfg_meta;
    end
  end
  wire cfg_two_wire = cfg[17];
  wire cfg_pick = cfg[16];
  wire cfg_hs_always = cfg[15];
  wire cfg_general_input = cfg[14];
  wire [6:0] cfg_prim = cfg[13:7];
  wire [6:0] cfg_alt = cfg[6:0];

  logic scl_f, sda_f, scl_q, sda_q;
  bus_line_sync scl_sync (
    .clk(link_clk),
    .rstn(lrstn),
    .din(serial_clock_pin),
    .bypass(hs_mode),
    .dout(scl_f)
  );
  bus_line_sync sda_sync (
    .clk(link_clk),
    .rstn(lrstn),
    .din(sda_in),
    .bypass(hs_mode),
    .dout(sda_f)
  );

  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // =====================================================================
  // bus conditions and decode
  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire bus_start = scl_f & scl_q & sda_q & ~sda_f;
  wire bus_stop = scl_f & scl_q & ~sda_q & sda_f;
  logic soft_rst;
  wire halt = soft_rst | ~cfg_two_wire;

  two_wire_pkg::link_state_e state;
  logic [3:0] bitcnt;
  logic [7:0] shreg, txsh, tx_next, ptr, ans_data;
  logic rw, hi_pages, master_ack, frame_alt, alt_addr_phase, hs_active;
  logic wr_pulse, rd_pulse, rd_done;
  logic [two_wire_pkg::REG_ADDR_W-1:0] lk_addr;
  logic [7:0] lk_wdata;

  wire [6:0] base_addr = (cfg_pick && cfg_general_input) ? cfg_alt : cfg_prim;
  wire hit_base = shreg[7:1] == base_addr;
  wire hit_high = shreg[7:1] == 7'(base_addr + two_wire_pkg::HIGH_PAGES_STEP);
  wire addr_hit = hit_base | hit_high;
  wire master_code = shreg[7:3] == two_wire_pkg::MASTER_CODE_TOP;
  wire run = ~halt & ~bus_start & ~bus_stop & (state != two_wire_pkg::ST_IDLE);
  wire at_last = run & scl_fall & (bitcnt == two_wire_pkg::LAST_DATA_BIT);
  wire at_ack_end = run & scl_fall & (bitcnt == two_wire_pkg::ACK_BIT);
  wire in_dev = state == two_wire_pkg::ST_DEVADDR;
  wire in_rd = state == two_wire_pkg::ST_RDATA;
  wire in_wr = state == two_wire_pkg::ST_WDATA;
  wire ack_now = (in_dev & addr_hit & ~master_code) | (state == two_wire_pkg::ST_REGADDR) | in_wr;

  // prefetch keeps read data ready at the clock fall, so no stretching is needed
  wire fetch_first = at_last & in_dev & addr_hit & ~master_code & shreg[0];
  wire fetch_more = at_ack_end & ((in_dev & rw) | (in_rd & master_ack));
  wire fetch_go = fetch_first | fetch_more;
  wire [7:0] fetch_ptr = fetch_first ? ptr : 8'(ptr + 8'h01);
  wire fetch_pair = (fetch_first ? hit_high : hi_pages) | page_control[two_wire_pkg::PCTL_PAGE_MSB];
  wire page_pair = hi_pages | page_control[two_wire_pkg::PCTL_PAGE_MSB];
  wire commit_wr = at_ack_end & in_wr & ~(frame_alt & alt_addr_phase);
  wire to_page_ctl = ptr[6:0] == two_wire_pkg::PAGE_CTL_OFFSET;

  // =====================================================================
  // protocol engine
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      state <= two_wire_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      hi_pages <= 1'b0;
      master_ack <= 1'b0;
      frame_alt <= 1'b0;
      alt_addr_phase <= 1'b0;
      hs_active <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (halt) begin
      state <= two_wire_pkg::ST_IDLE;
      sda_oe_n <= 1'b1;
      hs_active <= 1'b0;
    end else if (bus_start) begin
      state <= two_wire_pkg::ST_DEVADDR;
      bitcnt <= two_wire_pkg::START_FALL_BIT; // the START's own clock fall must not count as a bit
      sda_oe_n <= 1'b1;
      frame_alt <= page_control[two_wire_pkg::PCTL_WMODE_BIT];
    end else if (bus_stop) begin
      state <= two_wire_pkg::ST_IDLE;
      sda_oe_n <= 1'b1;
      hs_active <= 1'b0;
    end else if (state != two_wire_pkg::ST_IDLE) begin
      if (scl_rise && bitcnt != two_wire_pkg::ACK_BIT) begin
        shreg <= {shreg[6:0], sda_f};
      end
      if (scl_rise && bitcnt == two_wire_pkg::ACK_BIT && in_rd) begin
        master_ack <= ~sda_f;
        if (!sda_f) begin
          ptr <= ptr + 8'h01;
        end
      end
      if (scl_fall && (bitcnt < two_wire_pkg::LAST_DATA_BIT || bitcnt == two_wire_pkg::START_FALL_BIT)) begin
        bitcnt <= bitcnt + 4'h1;
        if (in_rd) begin
          sda_oe_n <= txsh[6];
          txsh <= {txsh[6:0], 1'b0};
        end
      end else if (at_last) begin
        bitcnt <= two_wire_pkg::ACK_BIT;
        sda_oe_n <= ~ack_now;
        if (in_dev) begin
          rw <= shreg[0];
          hi_pages <= hit_high;
          if (master_code) begin
            hs_active <= 1'b1;
            state <= two_wire_pkg::ST_SKIP;
          end else if (!addr_hit) begin
            state <= two_wire_pkg::ST_SKIP;
          end
        end
        if (state == two_wire_pkg::ST_REGADDR) begin
          ptr <= shreg;
          alt_addr_phase <= 1'b0;
        end
      end else if (at_ack_end) begin
        bitcnt <= 4'h0;
        sda_oe_n <= 1'b1;
        if (in_dev) begin
          state <= rw ? two_wire_pkg::ST_RDATA : two_wire_pkg::ST_REGADDR;
        end
        if (state == two_wire_pkg::ST_REGADDR) begin
          state <= two_wire_pkg::ST_WDATA;
        end
        if (in_wr) begin
          alt_addr_phase <= frame_alt & ~alt_addr_phase;
          if (frame_alt && alt_addr_phase) begin
            ptr <= shreg;
          end else if (!frame_alt) begin
            ptr <= ptr + 8'h01;
          end
        end
        if ((in_dev && rw) || (in_rd && master_ack)) begin
          sda_oe_n <= tx_next[7];
          txsh <= tx_next;
        end else if (in_rd) begin
          state <= two_wire_pkg::ST_SKIP;
        end
      end
    end
  end

  // =====================================================================
  // page control, register requests and read buffer
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      page_control <= two_wire_pkg::PCTL_RESET;
      tx_next <= 8'h00;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      lk_addr <= '0;
      lk_wdata <= 8'h00;
      hs_mode <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      hs_mode <= hs_active | cfg_hs_always;
      wr_pulse <= commit_wr & ~to_page_ctl;
      rd_pulse <= fetch_go & (fetch_ptr[6:0] != two_wire_pkg::PAGE_CTL_OFFSET);
      if (rd_done) begin
        tx_next <= ans_data;
      end
      if (fetch_go) begin
        lk_addr <= {fetch_pair, fetch_ptr};
        if (fetch_ptr[6:0] == two_wire_pkg::PAGE_CTL_OFFSET) begin
          tx_next <= page_control;
        end
      end
      if (commit_wr) begin
        lk_addr <= {page_pair, ptr};
        lk_wdata <= shreg;
        if (to_page_ctl) begin
          page_control <= shreg;
        end
      end else if (bus_stop && !halt && page_control[two_wire_pkg::PCTL_AUTO_PAGE_RETURN_BIT]) begin
        page_control <= page_control & ~two_wire_pkg::PCTL_PAGE_MASK;
      end
    end
  end

  // =====================================================================
  // clk domain: idle timeout and register access
  logic scl_m, scl_s, scl_p, to_pulse, wr_arrive, rd_arrive, rd_en_q, ans_pulse;
  logic [CNT_W-1:0] idle_cnt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      idle_cnt <= '0;
      to_pulse <= 1'b0;
    end else begin
      scl_m <= serial_clock_pin;
      scl_s <= scl_m;
      scl_p <= scl_s;
      to_pulse <= 1'b0;
      if (!bus_idle_timeout_enable || scl_s != scl_p) begin
        idle_cnt <= '0;
      end else if (idle_cnt == CNT_W'(TIMEOUT_CYCLES - 1)) begin
        idle_cnt <= '0;
        to_pulse <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  event_cross to_cross (
    .src_clk(clk), .src_rstn(rstn), .src_pulse(to_pulse),
    .dst_clk(link_clk), .dst_rstn(lrstn), .dst_pulse(soft_rst)
  );
  event_cross wr_cross (
    .src_clk(link_clk), .src_rstn(lrstn), .src_pulse(wr_pulse),
    .dst_clk(clk), .dst_rstn(rstn), .dst_pulse(wr_arrive)
  );
  event_cross rd_cross (
    .src_clk(link_clk), .src_rstn(lrstn), .src_pulse(rd_pulse),
    .dst_clk(clk), .dst_rstn(rstn), .dst_pulse(rd_arrive)
  );
  event_cross ans_cross (
    .src_clk(clk), .src_rstn(rstn), .src_pulse(ans_pulse),
    .dst_clk(link_clk), .dst_rstn(lrstn), .dst_pulse(rd_done)
  );

  // lk_addr and lk_wdata stand still long after their event, so sampling here is safe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_addr <= '0;
      reg_wdata <= 8'h00;
      rd_en_q <= 1'b0;
      ans_pulse <= 1'b0;
      ans_data <= 8'h00;
      shared_pins_free <= 1'b0;
    end else begin
      shared_pins_free <= two_wire_select;
      reg_wr_en <= wr_arrive;
      reg_rd_en <= rd_arrive;
      rd_en_q <= reg_rd_en;
      ans_pulse <= rd_en_q;
      if (wr_arrive || rd_arrive) begin
        reg_addr <= lk_addr;
      end
      if (wr_arrive) begin
        reg_wdata <= lk_wdata;
      end
      if (rd_en_q) begin
        ans_data <= reg_exists ? reg_rdata : 8'h00;
      end
    end
  end

  // =====================================================================
  // checks
  chk_start_restart: assert property (@(posedge link_clk) disable iff (!lrstn)
    (bus_start && !halt) |=> state == two_wire_pkg::ST_DEVADDR && bitcnt == two_wire_pkg::START_FALL_BIT && sda_oe_n)
    else $error("start did not restart the frame");
  chk_stop_to_idle: assert property (@(posedge link_clk) disable iff (!lrstn)
    (bus_stop && !halt) |=> (state == two_wire_pkg::ST_IDLE) && sda_oe_n)
    else $error("stop did not return to idle");
  chk_address_ack: assert property (@(posedge link_clk) disable iff (!lrstn)
    (at_last && in_dev && addr_hit && !master_code) |=> (!sda_oe_n) [*2])
    else $error("own address not acknowledged");
  chk_sda_change_low: assert property (@(posedge link_clk) disable iff (!lrstn)
    ($changed(sda_oe_n) && !$past(bus_start || bus_stop || halt)) |-> !scl_f)
    else $error("data line moved while clock high");
  chk_hs_entry: assert property (@(posedge link_clk) disable iff (!lrstn)
    (at_last && in_dev && master_code) |=> hs_active ##1 hs_mode)
    else $error("master code did not enter high speed");
  chk_auto_page_return_page: assert property (@(posedge link_clk) disable iff (!lrstn)
    (bus_stop && !halt && page_control[two_wire_pkg::PCTL_AUTO_PAGE_RETURN_BIT])
    |=> (page_control & two_wire_pkg::PCTL_PAGE_MASK) == 8'h00)
    else $error("auto page return missed");
  chk_frame_mode: assert property (@(posedge link_clk) disable iff (!lrstn)
    (bus_start && !halt) |=> frame_alt == $past(page_control[two_wire_pkg::PCTL_WMODE_BIT]))
    else $error("write mode not latched at start");
  chk_write_after_ack: assert property (@(posedge link_clk) disable iff (!lrstn)
    wr_pulse |-> ($past(bitcnt) == two_wire_pkg::ACK_BIT) && ($past(state) == two_wire_pkg::ST_WDATA))
    else $error("write issued before acknowledge");
  chk_timeout_fire: assert property (@(posedge clk) disable iff (!rstn)
    to_pulse |-> ($past(idle_cnt) == CNT_W'(TIMEOUT_CYCLES - 1)) && $past(bus_idle_timeout_enable))
    else $error("timeout fired at wrong count");
  chk_missing_zero: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd_en ##1 !reg_exists) |=> ans_data == 8'h00)
    else $error("missing register did not read zero");
endmodule
`default_nettype wire

// file: tb/host_master.sv
// bit-level host bus master model driving the clock line and pulling the data line
`default_nettype none
module host_master (
  // bus lines
  output logic scl,
  output logic sda_rel,
  input wire logic sda,
  // alignment clock
  input wire logic link_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // a quarter bit: five link cycles keeps every move on the same link phase
  localparam time Q = 150ns;
  // the data line is only pulled low or released and the pull-up makes the high; the clock line is driven both high and low
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // =====================================================================
  // framing
  task automatic start();
    if (scl === 1'b0) begin
      sda_rel = 1'b1;
      #Q;
      scl = 1'b1;
      #Q;
    end else begin
      @(posedge link_clk);
      #1;
    end
    sda_rel = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_rel = 1'b1;
    #Q;
  endtask
  // =====================================================================
  // bits and bytes
  // data moves only while the clock is low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    #Q;
    scl = 1'b1;
    #Q;
    r = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  // msb first, ninth clock is the acknowledge
  task automatic xfer(input logic [7:0] tx, input logic ackin, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ackin, ack);
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the two-wire slave register port
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic two_wire_select = 1'b1;
  logic [7:0] primary_bus_address = 8'hd0;
  logic [7:0] alternate_bus_address = 8'h40;
  logic address_pick_enable = 1'b0;
  logic hs_mode_always = 1'b0;
  logic bus_idle_timeout_enable = 1'b0;
  logic general_input = 1'b0;
  logic [7:0] reg_rdata = 8'h00;
  logic reg_exists = 1'b0;
  logic sda_o, sda_oe_n, shared_pins_free, hs_mode, reg_wr_en, reg_rd_en;
  logic [7:0] page_control, reg_wdata;
  logic [two_wire_pkg::REG_ADDR_W-1:0] reg_addr;
  wire logic scl;
  wire logic sda_rel;
  wire logic sda;
  logic [16:0] wq[$];
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  // open-drain wire: low if anyone pulls, else the pull-up
  assign sda = sda_rel & (sda_oe_n | sda_o);
  always #2.5 clk = ~clk;
  initial begin
    #7.3;
    forever #15 link_clk = ~link_clk;
  end
  host_master m (.scl(scl), .sda_rel(sda_rel), .sda(sda), .link_clk(link_clk));
  // short idle timeout so the stall test stays brief
  two_wire_slave_register_port #(.TIMEOUT_CYCLES(200)) dut (
    .clk(clk), .rstn(rstn), .link_clk(link_clk), .two_wire_select(two_wire_select),
    .primary_bus_address(primary_bus_address), .alternate_bus_address(alternate_bus_address),
    .address_pick_enable(address_pick_enable), .hs_mode_always(hs_mode_always),
    .bus_idle_timeout_enable(bus_idle_timeout_enable), .general_input(general_input),
    .serial_clock_pin(scl), .sda_in(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .shared_pins_free(shared_pins_free), .page_control(page_control), .hs_mode(hs_mode),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_exists(reg_exists));
  // =====================================================================
  // register side model: offsets 0x70 and up are missing and return junk
  always @(posedge clk) begin
    if (reg_wr_en === 1'b1)
      wq.push_back({reg_addr, reg_wdata});
    if (reg_rd_en === 1'b1) begin
      reg_exists <= #1 (reg_addr[6:0] < 7'h70);
      reg_rdata <= #1 (reg_addr[6:0] < 7'h70) ? (reg_addr[7:0] ^ 8'h3c) : 8'ha5;
    end
  end
  // =====================================================================
  // verdict and hang guard
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // =====================================================================
  // access tasks
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic ack;
    m.xfer(b, 1'b1, rx, ack);
    `CHK("ack", exp_ack, ack)
  endtask
  task automatic recv(input logic [7:0] exp, input logic more);
    logic [7:0] rx;
    logic ack;
    m.xfer(8'hff, ~more, rx, ack);
    `CHK("rdata", exp, rx)
  endtask
  task automatic exp_wr(input logic [16:0] e);
    logic [16:0] got;
    got = (wq.size() > 0) ? wq.pop_front() : 17'h1_ffff;
    `CHK("wr", e, got)
  endtask
  task automatic wframe(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d);
    m.start();
    send(dev, 1'b0);
    send(a, 1'b0);
    send(d, 1'b0);
    m.stop();
  endtask
  task automatic cfg();
    @(posedge clk);
    #1;
  endtask
  task automatic link_wait();
    repeat (10) @(posedge link_clk);
  endtask
  // =====================================================================
  // test sequence
  initial begin
    logic r;
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (20) @(posedge link_clk);
    `CHK("free", 1'b1, shared_pins_free)
    `CHK("pctl", 8'h00, page_control)
    `CHK("oe", 1'b1, sda_oe_n)
    wframe(8'hd0, 8'h55, 8'h3c);
    exp_wr({9'h055, 8'h3c});
    m.start();
    send(8'hd0, 1'b0);
    send(8'h10, 1'b0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    m.stop();
    exp_wr({9'h010, 8'h11});
    exp_wr({9'h011, 8'h22});
    // read across into a missing register, with a repeated start
    m.start();
    send(8'hd0, 1'b0);
    send(8'h6e, 1'b0);
    m.start();
    send(8'hd1, 1'b0);
    recv(8'h52, 1'b1);
    recv(8'h53, 1'b1);
    recv(8'h00, 1'b0);
    m.stop();
    // address filter and address pick
    m.start();
    send(8'ha0, 1'b1);
    m.stop();
    cfg();
    address_pick_enable = 1'b1;
    general_input = 1'b1;
    m.start();
    send(8'h40, 1'b0);
    m.stop();
    m.start();
    send(8'hd0, 1'b1);
    m.stop();
    cfg();
    address_pick_enable = 1'b0;
    `CHK("nwr", 0, wq.size())
    // paging: page lsb ignored, base plus one, auto return
    wframe(8'hd0, 8'h00, 8'h03);
    `CHK("pctl", 8'h03, page_control)
    wframe(8'hd0, 8'h05, 8'h9a);
    exp_wr({9'h105, 8'h9a});
    wframe(8'hd0, 8'h00, 8'h00);
    wframe(8'hd2, 8'h85, 8'h77);
    exp_wr({9'h185, 8'h77});
    wframe(8'hd0, 8'h00, 8'h83);
    `CHK("pctl", 8'h80, page_control)
    // alternating mode only from the next frame
    m.start();
    send(8'hd0, 1'b0);
    send(8'h00, 1'b0);
    send(8'h40, 1'b0);
    send(8'h55, 1'b0);
    m.stop();
    exp_wr({9'h001, 8'h55});
    m.start();
    send(8'hd0, 1'b0);
    send(8'h10, 1'b0);
    send(8'haa, 1'b0);
    send(8'h30, 1'b0);
    send(8'hbb, 1'b0);
    m.stop();
    exp_wr({9'h010, 8'haa});
    exp_wr({9'h030, 8'hbb});
    wframe(8'hd0, 8'h00, 8'h00);
    `CHK("pctl", 8'h00, page_control)
    // high-speed entry by master code, and permanent
    m.start();
    send(8'h08, 1'b1);
    link_wait();
    `CHK("hs", 1'b1, hs_mode)
    m.stop();
    link_wait();
    `CHK("hs", 1'b0, hs_mode)
    cfg();
    hs_mode_always = 1'b1;
    link_wait();
    `CHK("hs", 1'b1, hs_mode)
    wframe(8'hd0, 8'h12, 8'h34);
    exp_wr({9'h012, 8'h34});
    cfg();
    hs_mode_always = 1'b0;
    // start, then stop, inside a data byte drop the message
    m.start();
    send(8'hd0, 1'b0);
    send(8'h22, 1'b0);
    repeat (4) m.bit_io(1'b0, r);
    m.start();
    send(8'hd0, 1'b0);
    send(8'h23, 1'b0);
    send(8'h66, 1'b0);
    repeat (4) m.bit_io(1'b0, r);
    m.stop();
    exp_wr({9'h023, 8'h66});
    `CHK("nwr", 0, wq.size())
    // clock stall beyond the idle limit resets the engine
    cfg();
    bus_idle_timeout_enable = 1'b1;
    m.start();
    send(8'hd0, 1'b0);
    #2010;
    send(8'h10, 1'b1);
    m.stop();
    cfg();
    bus_idle_timeout_enable = 1'b0;
    two_wire_select = 1'b0;
    link_wait();
    `CHK("free", 1'b0, shared_pins_free)
    m.start();
    send(8'hd0, 1'b1);
    m.stop();
    report_and_stop();
  end
endmodule
`default_nettype wire
